/* File: hw/sync_serial_pkg.sv */
// Constants, register map and carrier types of the synchronous serial input port
package sync_serial_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int CHAIN_BITS_DEF = 64;          // Eight cascaded 8-bit stages
	localparam int BYTE_W         = 8;
	localparam int AD_W           = 8;           // Multiplexed address/data bus
	localparam int MUX_PORTS      = 3;           // Ports per multiplexer
	localparam int N_MUX          = 2;
	localparam int DEC_OUTS       = 8;           // 3-to-8 select decoder
	localparam int ADDR_IDX_LSB   = 0;           // Decoder input field
	localparam int ADDR_IDX_W     = 3;
	localparam int ADDR_PORT_LSB  = 3;           // Port select field
	localparam int ADDR_PORT_W    = 2;

	// ----------------------------------------------------------------
	// Select decoder outputs
	// ----------------------------------------------------------------
	localparam logic [2:0] DEC_FIRST_MUX  = 3'h0;
	localparam logic [2:0] DEC_SECOND_MUX = 3'h1;
	localparam logic [2:0] DEC_STATUS     = 3'h2;
	localparam logic [2:0] DEC_BYTE6      = 3'h3;
	localparam logic [2:0] DEC_BYTE7      = 3'h4;
	localparam logic [2:0] BYTE6_IDX      = 3'h6;
	localparam logic [2:0] BYTE7_IDX      = 3'h7;

	typedef enum logic [1:0] {
		PORT_A    = 2'b00,
		PORT_B    = 2'b01,
		PORT_C    = 2'b10,
		PORT_NONE = 2'b11
	} port_sel_t;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int AXI_AW = 8;
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_STATUS   = 8'h04;
	localparam logic [7:0] OFF_INT_STAT = 8'h08;
	localparam logic [7:0] OFF_INT_CLR  = 8'h0C;
	localparam logic [7:0] OFF_INT_EN   = 8'h10;
	localparam logic [7:0] OFF_DATA_LO  = 8'h14;
	localparam logic [7:0] OFF_DATA_HI  = 8'h18;
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_REARM_BIT = 1;
	localparam logic CTRL_EN_RESET = 1'b1;
	localparam int EV_FULL    = 0;
	localparam int EV_DRAINED = 1;
	localparam int N_EV       = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [AD_W-1:0] ad;
		logic            ale_n;
		logic            rd_n;
		logic            wr_n;
		logic            gate;
		logic            sclk;
		logic            sdata;
	} pins_t;

	localparam pins_t PINS_IDLE = '{ad: 8'h00, ale_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1,
		gate: 1'b0, sclk: 1'b0, sdata: 1'b0};

endpackage : sync_serial_pkg

/* File: hw/sync_serial_input_port.sv */
// Synchronous serial input port: 64-bit shift chain read by a processor through two multiplexers and decoder outputs three/four
//
// Design decisions made here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Address strobe low captures bus into register
// - Decoder output active only with gate bit
// - Decoder outputs zero/one low select multiplexers
// - Serial bits shift through one 64-bit chain
// - Full chain flagged, readable via status path
// - Processor reads all eight bytes, then rearmed
// - Each multiplexer offers three byte-wide ports
// - Select 00/01/10 picks port A/B/C
// - Read passes port to bus, write reverse
// - Unselected multiplexer leaves bus undriven
module sync_serial_input_port
	import sync_serial_pkg::*;
#(
	parameter int CHAIN_BITS = CHAIN_BITS_DEF
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           ce,
	input  wire logic [AXI_AW-1:0]              s_axi_awaddr,
	input  wire logic                           s_axi_awvalid,
	output      logic                           s_axi_awready,
	input  wire logic [31:0]                    s_axi_wdata,
	input  wire logic [3:0]                     s_axi_wstrb,
	input  wire logic                           s_axi_wvalid,
	output      logic                           s_axi_wready,
	output      logic [1:0]                     s_axi_bresp,
	output      logic                           s_axi_bvalid,
	input  wire logic                           s_axi_bready,
	input  wire logic [AXI_AW-1:0]              s_axi_araddr,
	input  wire logic                           s_axi_arvalid,
	output      logic                           s_axi_arready,
	output      logic [31:0]                    s_axi_rdata,
	output      logic [1:0]                     s_axi_rresp,
	output      logic                           s_axi_rvalid,
	input  wire logic                           s_axi_rready,
	input  wire logic [AD_W-1:0]                ad_in,
	output      logic [AD_W-1:0]                ad_out,
	output      logic                           ad_oe_n,
	input  wire logic                           ale_n,
	input  wire logic                           rd_n,
	input  wire logic                           wr_n,
	input  wire logic                           decode_gate_bit,
	input  wire logic                           chain_clk,
	input  wire logic                           chain_serial_in,
	output      logic [DEC_OUTS-1:0]            mux_select_n,
	output      logic [N_MUX*MUX_PORTS*BYTE_W-1:0] port_out,
	output      logic                           chain_full,
	output      logic                           irq
);

	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (CHAIN_BITS != CHAIN_BITS_DEF) begin : g_bad_len
		$error("shift chain must be 64 bits");
	end

	localparam int CNT_W = $clog2(CHAIN_BITS + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CHAIN_BITS - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(CHAIN_BITS);
	localparam int N_BYTES = CHAIN_BITS / BYTE_W;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		pins_t                                   p1;
		pins_t                                   p2;
		pins_t                                   p3;
		logic [CHAIN_BITS-1:0]                   chain;
		logic [CNT_W-1:0]                        count;
		logic                                    full;
		logic [N_BYTES-1:0]                      read_mask;
		logic [AD_W-1:0]                         addr;
		logic [N_MUX*MUX_PORTS-1:0][BYTE_W-1:0]  ports;
		logic [AD_W-1:0]                         ad_out;
		logic                                    ad_oe_n;
		logic                                    ctrl_en;
		logic [N_EV-1:0]                         int_stat;
		logic [N_EV-1:0]                         int_en;
		logic                                    aw_held;
		logic [AXI_AW-1:0]                       awaddr;
		logic                                    w_held;
		logic [31:0]                             wdata;
		logic                                    wstrb0;
		logic                                    bvalid;
		logic [1:0]                              bresp;
		logic                                    rvalid;
		logic [31:0]                             rdata;
		logic [1:0]                              rresp;
	} state_t;

	localparam state_t STATE_RESET = '{p1: PINS_IDLE, p2: PINS_IDLE, p3: PINS_IDLE,
		ctrl_en: CTRL_EN_RESET, ad_oe_n: 1'b1, default: '0};

	state_t s;
	state_t next_s;
	pins_t  pins_in;

	logic                  ale_fall;
	logic                  rd_fall;
	logic                  wr_rise;
	logic                  shift_go;
	logic                  drain_go;
	port_sel_t             psel;
	logic [1:0]            port_idx;
	logic                  port_ok;
	logic                  byte_hit;
	logic [2:0]            byte_idx;
	logic                  stat_hit;
	logic                  mux_hit;
	logic                  wr_hit;
	logic [2:0]            wr_idx;
	logic [ADDR_IDX_W-1:0] dec_idx;

	assign pins_in = '{ad: ad_in, ale_n: ale_n, rd_n: rd_n, wr_n: wr_n,
		gate: decode_gate_bit, sclk: chain_clk, sdata: chain_serial_in};

	// Edges seen on synchronised pins only
	assign ale_fall = !s.p2.ale_n && s.p3.ale_n;
	assign rd_fall  = !s.p2.rd_n && s.p3.rd_n;
	assign wr_rise  = s.p2.wr_n && !s.p3.wr_n;
	assign shift_go = s.p2.sclk && !s.p3.sclk && s.ctrl_en && !s.full;
	assign drain_go = s.full && (&s.read_mask);
	assign psel     = port_sel_t'(s.addr[ADDR_PORT_LSB +: ADDR_PORT_W]);
	assign dec_idx  = s.addr[ADDR_IDX_LSB +: ADDR_IDX_W];

	// ----------------------------------------------------------------
	// Multiplexer select decoder
	// ----------------------------------------------------------------
	for (genvar g = 0; g < DEC_OUTS; g++) begin : g_dec
		assign mux_select_n[g] = !(s.p2.gate && dec_idx == ADDR_IDX_W'(g));
	end

	// Port decode and what the selected path reaches
	always_comb begin
		port_idx = 2'h0;
		port_ok  = 1'b0;
		unique case (psel)
			PORT_A:    begin port_idx = 2'h0; port_ok = 1'b1; end
			PORT_B:    begin port_idx = 2'h1; port_ok = 1'b1; end
			PORT_C:    begin port_idx = 2'h2; port_ok = 1'b1; end
			PORT_NONE: begin port_idx = 2'h0; port_ok = 1'b0; end
		endcase
		mux_hit  = !mux_select_n[DEC_FIRST_MUX] || !mux_select_n[DEC_SECOND_MUX];
		byte_hit = 1'b0;
		byte_idx = 3'h0;
		stat_hit = 1'b0;
		wr_hit   = mux_hit && port_ok;
		wr_idx   = mux_select_n[DEC_FIRST_MUX] ? 3'(MUX_PORTS + port_idx) : {1'b0, port_idx};
		if (mux_hit && port_ok) begin
			byte_hit = 1'b1;
			byte_idx = wr_idx;
		end else if (!mux_select_n[DEC_BYTE6]) begin
			byte_hit = 1'b1;
			byte_idx = BYTE6_IDX;
		end else if (!mux_select_n[DEC_BYTE7]) begin
			byte_hit = 1'b1;
			byte_idx = BYTE7_IDX;
		end else if (!mux_select_n[DEC_STATUS]) begin
			stat_hit = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [N_EV-1:0] ev;
		logic [N_EV-1:0] clr;
		logic            rearm;
		ev     = '0;
		clr    = '0;
		rearm  = 1'b0;
		next_s = s;
		// Two-flop synchronisers, third stage only for edge detection
		next_s.p1 = pins_in;
		next_s.p2 = s.p1;
		next_s.p3 = s.p2;
		// Address capture on strobe
		if (ale_fall) begin
			next_s.addr = s.p2.ad;
		end
		// Shift chain
		if (shift_go) begin
			next_s.chain = {s.chain[CHAIN_BITS-2:0], s.p2.sdata};
			next_s.count = s.count + CNT_W'(1);
			if (s.count == CNT_LAST) begin
				next_s.full  = 1'b1;
				ev[EV_FULL]  = 1'b1;
			end
		end
		// Bus-side read drive
		next_s.ad_oe_n = 1'b1;
		if (!s.p2.rd_n) begin
			if (byte_hit) begin
				next_s.ad_oe_n = 1'b0;
				next_s.ad_out  = s.chain[byte_idx*BYTE_W +: BYTE_W];
			end else if (mux_hit) begin
				next_s.ad_oe_n = 1'b0;
				next_s.ad_out  = '0;
			end else if (stat_hit) begin
				next_s.ad_oe_n = 1'b0;
				next_s.ad_out  = AD_W'(s.full);
			end
		end
		if (rd_fall && byte_hit && s.full) begin
			next_s.read_mask[byte_idx] = 1'b1;
		end
		// Write direction into the selected port
		if (wr_rise && wr_hit) begin
			next_s.ports[wr_idx] = s.p2.ad;
		end
		// Register write
		next_s.bvalid = s.bvalid && !s_axi_bready;
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.aw_held = 1'b1;
			next_s.awaddr  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.w_held = 1'b1;
			next_s.wdata  = s_axi_wdata;
			next_s.wstrb0 = s_axi_wstrb[0];
		end
		if (s.aw_held && s.w_held && !s.bvalid) begin
			next_s.aw_held = 1'b0;
			next_s.w_held  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = RESP_OKAY;
			unique case (s.awaddr)
				OFF_CTRL: if (s.wstrb0) begin
					next_s.ctrl_en = s.wdata[CTRL_EN_BIT];
					rearm          = s.wdata[CTRL_REARM_BIT];
				end
				OFF_INT_CLR: if (s.wstrb0) clr = s.wdata[N_EV-1:0];
				OFF_INT_EN: if (s.wstrb0) next_s.int_en = s.wdata[N_EV-1:0];
				OFF_STATUS, OFF_INT_STAT, OFF_DATA_LO, OFF_DATA_HI: ;
				default: next_s.bresp = RESP_SLVERR;
			endcase
		end
		// Register read
		next_s.rvalid = s.rvalid && !s_axi_rready;
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = RESP_OKAY;
			next_s.rdata  = '0;
			unique case (s_axi_araddr)
				OFF_CTRL:     next_s.rdata[CTRL_EN_BIT] = s.ctrl_en;
				OFF_STATUS:   next_s.rdata = {8'h00, s.addr, s.read_mask, s.full, 7'(s.count)};
				OFF_INT_STAT: next_s.rdata[N_EV-1:0] = s.int_stat;
				OFF_INT_CLR:  ;
				OFF_INT_EN:   next_s.rdata[N_EV-1:0] = s.int_en;
				OFF_DATA_LO:  next_s.rdata = s.chain[31:0];
				OFF_DATA_HI:  next_s.rdata = s.chain[CHAIN_BITS-1:32];
				default:      next_s.rresp = RESP_SLVERR;
			endcase
		end
		// Rearm once every byte has been taken, or on software request
		if (drain_go || (rearm && !ev[EV_FULL])) begin // Completing fill wins over rearm
			next_s.full      = 1'b0;
			next_s.count     = '0;
			next_s.read_mask = '0;
			ev[EV_DRAINED]   = drain_go;
		end
		// Sticky events, set wins over clear
		next_s.int_stat = (s.int_stat & ~clr) | ev;
		// Clock enable freezes everything
		if (!ce) begin
			next_s = s;
		end
	end

	// Register the whole state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = ce && !s.aw_held && !s.bvalid;
	assign s_axi_wready  = ce && !s.w_held && !s.bvalid;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_arready = ce && !s.rvalid;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign ad_out        = s.ad_out;
	assign ad_oe_n       = s.ad_oe_n;
	assign port_out      = s.ports;
	assign chain_full    = s.full;
	assign irq           = |(s.int_stat & s.int_en);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	addr_capture_a: assert property (ce && ale_fall |=> s.addr == $past(s.p2.ad))
		else $error("address not captured on strobe");
	decode_gate_a: assert property (!s.p2.gate |-> mux_select_n == 8'hFF)
		else $error("decoder active without gate bit");
	decode_sel_a: assert property (s.p2.gate && dec_idx == DEC_SECOND_MUX
		|-> !mux_select_n[DEC_SECOND_MUX] && $countones(mux_select_n) == DEC_OUTS - 1)
		else $error("wrong decoder output selected");
	chain_shift_a: assert property (ce && shift_go
		|=> s.chain == {$past(s.chain[CHAIN_BITS-2:0]), $past(s.p2.sdata)})
		else $error("chain did not shift");
	chain_full_a: assert property (ce && shift_go && s.count == CNT_LAST
		|=> s.full && s.count == CNT_FULL && s.int_stat[EV_FULL])
		else $error("full not flagged after last bit");
	drain_rearm_a: assert property (ce && drain_go |=> !s.full && s.count == '0 ##1 !chain_full)
		else $error("chain not rearmed after drain");
	port_read_a: assert property (ce && !s.p2.rd_n && !mux_select_n[DEC_FIRST_MUX] && psel == PORT_B
		|=> !ad_oe_n && ad_out == $past(s.chain[2*BYTE_W-1:BYTE_W]))
		else $error("port B byte not driven");
	port_write_a: assert property (ce && wr_rise && !mux_select_n[DEC_SECOND_MUX] && psel == PORT_C
		|=> s.ports[5] == $past(s.p2.ad))
		else $error("write did not reach port");
	bus_release_a: assert property (ce && (s.p2.rd_n || (&mux_select_n)) |=> ad_oe_n)
		else $error("bus driven while unselected");
	none_port_a: assert property (ce && !s.p2.rd_n && mux_hit && psel == PORT_NONE
		|=> !ad_oe_n && ad_out == 8'h00)
		else $error("unused select did not read zero");

endmodule : sync_serial_input_port

/* File: tb/serial_ctrl_model.sv */
// Behavioural remote controller that shifts words into the serial chain
`timescale 1ns/1ps
module serial_ctrl_model (
	input  wire logic aclk,
	output      logic sclk,
	output      logic sdata
);
	// Line idles low until the first frame
	initial begin
		sclk  = 1'b0;
		sdata = 1'b0;
	end

	// Sends nbits, most significant first; clock stands low between frames
	task automatic send(input logic [63:0] w, input int nbits, input int half);
		for (int i = nbits - 1; i >= 0; i--) begin
			sdata <= w[i];
			repeat (half) @(posedge aclk);
			sclk  <= 1'b1;
			repeat (half) @(posedge aclk);
			sclk  <= 1'b0;
		end
		// Released data line shows the inverse of the last bit
		sdata <= ~w[0];
		repeat (half) @(posedge aclk);
	endtask : send
endmodule : serial_ctrl_model

/* File: tb/test_sync_serial_input_port.sv */
// Self-checking bench for the synchronous serial input port
`timescale 1ns/1ps
module test_sync_serial_input_port import sync_serial_pkg::*;;
	localparam logic [63:0] WORD = 64'h0123_4567_89AB_CDEF;
	logic                              aclk, aresetn, ce;
	logic [AXI_AW-1:0]                 awaddr, araddr;
	logic [31:0]                       wdata, rdata, rd_word;
	logic [3:0]                        wstrb;
	logic [1:0]                        bresp, rresp, resp;
	logic                              awvalid, awready, wvalid, wready, bvalid, bready;
	logic                              arvalid, arready, rvalid, rready;
	logic [AD_W-1:0]                   ad_drv, ad_out, ad_bus, byte_got;
	logic                              ad_oe_n, ale_n, rd_n, wr_n, gate, sclk, sdata, oe_got;
	logic [DEC_OUTS-1:0]               mux_select_n;
	logic [N_MUX*MUX_PORTS*BYTE_W-1:0] port_out;
	logic                              chain_full, irq;
	int                                err_count, compares;

	// Shared bus: device output wins while its enable is low
	assign ad_bus = ad_oe_n ? ad_drv : ad_out;

	// 250 MHz clock
	always #2 aclk = ~aclk;

	sync_serial_input_port uut (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.ad_in(ad_bus), .ad_out(ad_out), .ad_oe_n(ad_oe_n), .ale_n(ale_n), .rd_n(rd_n), .wr_n(wr_n),
		.decode_gate_bit(gate), .chain_clk(sclk), .chain_serial_in(sdata),
		.mux_select_n(mux_select_n), .port_out(port_out), .chain_full(chain_full), .irq(irq)
	);

	serial_ctrl_model remote (.aclk(aclk), .sclk(sclk), .sdata(sdata));

	// ----------------------------------------------------------------
	// Report and compare
	// ----------------------------------------------------------------
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic give_up;
		err_count++;
		tally_and_finish();
	endtask : give_up

	task automatic chk_val(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val

	// ----------------------------------------------------------------
	// Register bus and processor pin tasks
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		resp = bresp;
		if (n == 100) give_up();
		@(posedge aclk);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		int n;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		rd_word = rdata;
		resp = rresp;
		if (n == 100) give_up();
		@(posedge aclk);
	endtask : axi_rd

	// Address on the bus, then a low strobe long enough for the synchronisers
	task automatic latch_addr(input logic [7:0] a, input logic g);
		ad_drv <= a;
		gate   <= g;
		@(posedge aclk);
		ale_n  <= 1'b0;
		repeat (4) @(posedge aclk);
		ale_n  <= 1'b1;
		repeat (5) @(posedge aclk);
	endtask : latch_addr

	task automatic pin_rd;
		ad_drv <= ~ad_drv;
		rd_n   <= 1'b0;
		repeat (5) @(posedge aclk);
		byte_got = ad_bus;
		oe_got   = ad_oe_n;
		rd_n   <= 1'b1;
		repeat (5) @(posedge aclk);
		chk_val({63'h0, ad_oe_n}, 64'h1);
	endtask : pin_rd

	task automatic pin_wr(input logic [7:0] d);
		ad_drv <= d;
		wr_n   <= 1'b0;
		repeat (4) @(posedge aclk);
		wr_n   <= 1'b1;
		repeat (5) @(posedge aclk);
	endtask : pin_wr

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		int n;
		aclk = 1'b0; aresetn = 1'b0; ce = 1'b1; wstrb = 4'hF;
		awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; awvalid = 1'b0; wvalid = 1'b0;
		bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
		ad_drv = 8'h00; ale_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; gate = 1'b0;
		err_count = 0;
		compares = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_val({56'h0, mux_select_n}, 64'hFF);
		chk_val({62'h0, chain_full, irq}, 64'h0);
		axi_rd(OFF_CTRL);
		chk_val({32'h0, rd_word}, 64'h1);
		axi_rd(8'hFC);
		chk_val({62'h0, resp}, {62'h0, RESP_SLVERR});
		axi_wr(OFF_INT_EN, 32'h1);
		chk_val({62'h0, resp}, {62'h0, RESP_OKAY});
		axi_wr(8'hFC, 32'h0);
		chk_val({62'h0, resp}, {62'h0, RESP_SLVERR});
		// Decoder outputs zero to four in turn, then the gate bit low
		for (int i = 0; i < 5; i++) begin
			latch_addr(8'(i), 1'b1);
			chk_val({56'h0, mux_select_n}, {56'h0, ~(8'h01 << i)});
		end
		latch_addr(8'h00, 1'b0);
		chk_val({56'h0, mux_select_n}, 64'hFF);
		pin_rd();
		chk_val({63'h0, oe_got}, 64'h1);
		latch_addr({5'h00, DEC_STATUS}, 1'b1);
		pin_rd();
		chk_val({56'h0, byte_got}, 64'h0);
		// Fill the chain, then extra slow bits that must be ignored
		remote.send(WORD, 64, 4);
		for (n = 0; n < 50 && chain_full !== 1'b1; n++) @(posedge aclk);
		if (n == 50) give_up();
		remote.send(64'hFF, 8, 8);
		chk_val({62'h0, chain_full, irq}, 64'h3);
		axi_rd(OFF_DATA_LO);
		chk_val({32'h0, rd_word}, {32'h0, WORD[31:0]});
		axi_rd(OFF_DATA_HI);
		chk_val({32'h0, rd_word}, {32'h0, WORD[63:32]});
		latch_addr({3'h0, PORT_NONE, DEC_FIRST_MUX}, 1'b1);
		pin_rd();
		chk_val({55'h0, oe_got, byte_got}, 64'h0);
		latch_addr({5'h00, DEC_STATUS}, 1'b1);
		pin_rd();
		chk_val({55'h0, oe_got, byte_got}, 64'h1);
		// All eight bytes through both multiplexers and the extra outputs
		for (int k = 0; k < 8; k++) begin
			latch_addr(k < 6 ? {3'h0, 2'(k % 3), 3'(k / 3)} : 8'(k - 3), 1'b1);
			pin_rd();
			chk_val({55'h0, oe_got, byte_got}, {56'h0, WORD[8*k +: 8]});
		end
		repeat (2) @(posedge aclk);
		chk_val({62'h0, chain_full, irq}, 64'h1);
		axi_rd(OFF_INT_STAT);
		chk_val({32'h0, rd_word}, 64'h3);
		// Mask, unmask the drained event, then clear both
		axi_wr(OFF_INT_EN, 32'h0);
		repeat (2) @(posedge aclk);
		chk_val({63'h0, irq}, 64'h0);
		axi_wr(OFF_INT_EN, 32'h2);
		repeat (2) @(posedge aclk);
		chk_val({63'h0, irq}, 64'h1);
		axi_wr(OFF_INT_CLR, 32'h3);
		axi_rd(OFF_INT_STAT);
		chk_val({31'h0, irq, rd_word}, 64'h0);
		// Write direction, including the unused port select
		latch_addr({3'h0, PORT_B, DEC_FIRST_MUX}, 1'b1);
		pin_wr(8'hA5);
		latch_addr({3'h0, PORT_C, DEC_SECOND_MUX}, 1'b1);
		pin_wr(8'h5A);
		latch_addr({3'h0, PORT_NONE, DEC_FIRST_MUX}, 1'b1);
		pin_wr(8'h3C);
		chk_val({16'h0, port_out}, {16'h0, 8'h5A, 24'h0, 8'hA5, 8'h00});
		// Partial fill, software rearm, then shifting held off by the enable bit and by ce
		remote.send(WORD, 8, 4);
		axi_rd(OFF_STATUS);
		chk_val({48'h0, rd_word[15:0]}, 64'h8);
		axi_wr(OFF_CTRL, 32'h3);
		axi_rd(OFF_STATUS);
		chk_val({48'h0, rd_word[15:0]}, 64'h0);
		axi_wr(OFF_CTRL, 32'h0);
		remote.send(WORD, 8, 4);
		axi_rd(OFF_CTRL);
		chk_val({32'h0, rd_word}, 64'h0);
		axi_rd(OFF_STATUS);
		chk_val({48'h0, rd_word[15:0]}, 64'h0);
		axi_wr(OFF_CTRL, 32'h1);
		ce <= 1'b0;
		remote.send(WORD, 8, 4);
		ce <= 1'b1;
		repeat (4) @(posedge aclk);
		axi_rd(OFF_STATUS);
		chk_val({48'h0, rd_word[15:0]}, 64'h0);
		tally_and_finish();
	end
endmodule : test_sync_serial_input_port
